// [hdl/dam_pkg.sv]
package dam_pkg;
  // timing
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned MOCK_HOLD_S = 5;
  localparam int unsigned MOCK_HOLD_CYC = MOCK_HOLD_S * CLK_HZ;
  localparam int unsigned BLINK_MS = 500;
  localparam int unsigned BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);
  localparam int unsigned SEC_CYC = CLK_HZ;
  // setting values
  localparam logic [7:0] MOCK_TRIG_VAL = 8'h01;
  localparam logic [7:0] DATA_INIT_VAL = 8'h0a;
  localparam logic [7:0] LALM_ASSIGN_VAL = 8'h62;
  // sizes
  localparam int NCAUSE = 32;
  localparam int NTERM = 4;
  localparam int HIST_D = 8;
  localparam int NPIN = 6;
  // synchronised pin positions
  localparam int PIN_STOP = 0;
  localparam int PIN_SET = 1;
  localparam int PIN_RKEY = 2;
  localparam int PIN_RST = 3;
  localparam int PIN_BATT = 4;
  localparam int PIN_LOST = 5;
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_MOCK = 8'h04;
  localparam logic [7:0] A_INIT = 8'h08;
  localparam logic [7:0] A_TIME = 8'h0c;
  localparam logic [7:0] A_DATE = 8'h10;
  localparam logic [7:0] A_SEL1 = 8'h14;
  localparam logic [7:0] A_SEL2 = 8'h18;
  localparam logic [7:0] A_ASGN = 8'h1c;
  localparam logic [7:0] A_STAT = 8'h20;
  localparam logic [7:0] A_ISTAT = 8'h24;
  localparam logic [7:0] A_IMASK = 8'h28;
  localparam logic [2:0] A_HIST_HI = 3'h2;
  // status and event bits
  localparam int CTRL_REL = 0;
  localparam int EV_MOCK = 0;
  localparam int EV_LOWB = 1;
  localparam int EV_DLOSS = 2;
  localparam int EV_LA_ON = 3;
  localparam int EV_LA_OFF = 4;
  localparam int EV_N = 5;
  // calendar limits and reset values
  localparam logic [7:0] YR_MAX = 8'h63;
  localparam logic [7:0] MON_MAX = 8'h0c;
  localparam logic [7:0] DAY_MAX = 8'h1f;
  localparam logic [7:0] HR_MAX = 8'h17;
  localparam logic [7:0] MIN_MAX = 8'h3b;
  localparam logic [7:0] YMD_RST = 8'h01;
endpackage

// [hdl/dam_rtc.sv]
`timescale 1ns/1ps
module dam_rtc #(
  parameter int unsigned SEC_CYC = dam_pkg::SEC_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control side
  dam_rtc_if.rtc r
);
  typedef struct packed {
    logic [31:0] div;
    logic [7:0] sec, min, hr, day, mon, yr;
    logic run;
    logic bad;
  } dam_rtc_st_t;
  localparam dam_rtc_st_t RTC_RST = '{div: '0, sec: '0, min: '0, hr: '0,
    day: dam_pkg::YMD_RST, mon: dam_pkg::YMD_RST, yr: '0, run: 1'b0, bad: 1'b0};
  dam_rtc_st_t s;
  dam_rtc_st_t next_s;
  logic [7:0] dim;
  logic at_end;

  always_comb begin
    next_s = s;
    if (r.init) begin
      next_s = RTC_RST;
    end else if (r.wr_time) begin
      {next_s.hr, next_s.min, next_s.sec} = r.wdata;
      next_s.div = '0;
      next_s.run = 1'b1;
    end else if (r.wr_date) begin
      {next_s.yr, next_s.mon, next_s.day} = r.wdata;
      next_s.run = 1'b1;
    end else if (s.run && !s.bad) begin
      if (s.div == 32'(SEC_CYC - 1)) begin
        next_s.div = '0;
        // holds at the last second of the last day of the range
        if (!at_end) begin
          next_s.sec = s.sec + 8'h01;
          if (s.sec == dam_pkg::MIN_MAX) begin
            next_s.sec = '0;
            next_s.min = s.min + 8'h01;
            if (s.min == dam_pkg::MIN_MAX) begin
              next_s.min = '0;
              next_s.hr = s.hr + 8'h01;
              if (s.hr == dam_pkg::HR_MAX) begin
                next_s.hr = '0;
                next_s.day = s.day + 8'h01;
                if (s.day == dim) begin
                  next_s.day = dam_pkg::YMD_RST;
                  next_s.mon = s.mon + 8'h01;
                  if (s.mon == dam_pkg::MON_MAX) begin
                    next_s.mon = dam_pkg::YMD_RST;
                    next_s.yr = s.yr + 8'h01;
                  end
                end
              end
            end
          end
        end
      end else begin
        next_s.div = s.div + 32'h1;
      end
    end
    next_s.bad = s.run && (s.sec > dam_pkg::MIN_MAX || s.min > dam_pkg::MIN_MAX ||
      s.hr > dam_pkg::HR_MAX || s.mon == '0 || s.mon > dam_pkg::MON_MAX ||
      s.day == '0 || s.day > dim || s.yr > dam_pkg::YR_MAX);
  end

  always_comb begin
    unique case (s.mon)
      8'h04, 8'h06, 8'h09, 8'h0b: dim = 8'h1e;
      8'h02: dim = (s.yr[1:0] == 2'b00) ? 8'h1d : 8'h1c;
      default: dim = dam_pkg::DAY_MAX;
    endcase
    at_end = s.yr == dam_pkg::YR_MAX && s.mon == dam_pkg::MON_MAX &&
      s.day == dam_pkg::DAY_MAX && s.hr == dam_pkg::HR_MAX &&
      s.min == dam_pkg::MIN_MAX && s.sec == dam_pkg::MIN_MAX;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= RTC_RST;
    end else begin
      s <= next_s;
    end
  end

  assign r.time_v = {s.hr, s.min, s.sec};
  assign r.date_v = {s.yr, s.mon, s.day};
  assign r.run = s.run;
  assign r.bad = s.bad;
endmodule

// [hdl/dam_rtc_if.sv]
`timescale 1ns/1ps
interface dam_rtc_if;
  logic init;
  logic wr_time;
  logic wr_date;
  logic [23:0] wdata;
  logic [23:0] time_v;
  logic [23:0] date_v;
  logic run;
  logic bad;
  modport ctl (output init, wr_time, wr_date, wdata, input time_v, date_v, run, bad);
  modport rtc (input init, wr_time, wr_date, wdata, output time_v, date_v, run, bad);
endinterface

// [hdl/dam_sync.sv]
`timescale 1ns/1ps
module dam_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // pins and clean levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } dam_sync_st_t;
  dam_sync_st_t s;
  dam_sync_st_t next_s;

  always_comb begin
    next_s = s;
    next_s.s1 = d_i;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    // a change counts once the second and third stages agree
    for (int i = 0; i < W; i++) begin
      if (s.s2[i] == s.s3[i]) begin
        next_s.q[i] = s.s3[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q_o = s.q;
endmodule

// [hdl/dam_top.sv]
// Design decisions made here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
module dam_top #(
  parameter int unsigned HOLD_CYC = dam_pkg::MOCK_HOLD_CYC,
  parameter int unsigned BLINK_CYC = dam_pkg::BLINK_CYC,
  parameter int unsigned SEC_CYC = dam_pkg::SEC_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // keypad and terminal pins
  input wire logic stop_key_i,
  input wire logic set_key_i,
  input wire logic reset_key_i,
  input wire logic alarm_rst_i,
  input wire logic batt_low_i,
  input wire logic backup_lost_i,
  // drive logic
  input wire logic run_mode_i,
  input wire logic [dam_pkg::NCAUSE-1:0] cause_i,
  // alarm outputs
  output logic mock_alarm_o,
  output logic low_batt_alarm_o,
  output logic date_loss_alarm_o,
  output logic trip_o,
  output logic caution_lamp_o,
  output logic [7:0] alarm_code_o,
  output logic [dam_pkg::NTERM-1:0] light_alarm_output_o,
  output logic irq_o
);
  typedef enum logic [1:0] {LA_IDLE, LA_ALARM, LA_RESERVED} dam_la_t;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic [dam_pkg::NPIN-1:0] pin_q;
    logic [31:0] hold;
    logic mock;
    logic lowb;
    logic dloss;
    logic trip;
    logic [7:0] mock_reg;
    logic [7:0] init_reg;
    logic [31:0] sel;
    logic [31:0] asgn;
    logic [dam_pkg::NCAUSE-1:0] cause_q;
    dam_la_t la;
    logic [7:0] code;
    logic [31:0] blink_cnt;
    logic blink;
    logic [dam_pkg::HIST_D-1:0][7:0] hist;
    logic [dam_pkg::EV_N-1:0] ist;
    logic [dam_pkg::EV_N-1:0] imask;
    logic irq;
    logic lamp;
    logic [7:0] code_o;
    logic [dam_pkg::NTERM-1:0] lout;
  } dam_top_st_t;

  dam_top_st_t s;
  dam_top_st_t next_s;
  dam_rtc_if rtc_bus ();
  logic [dam_pkg::NPIN-1:0] pin;
  logic acc;
  logic wr;
  logic rkey_rise;
  logic term_rise;
  logic comm_rel;
  logic rel_req;
  logic [dam_pkg::NCAUSE-1:0] la_src;
  logic [dam_pkg::NCAUSE-1:0] rise;
  logic [7:0] new_code;
  logic [dam_pkg::EV_N-1:0] ev;
  logic [31:0] rdata;
  logic dloss_cond;

  dam_sync #(
    .W(dam_pkg::NPIN)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({backup_lost_i, batt_low_i, alarm_rst_i, reset_key_i, set_key_i, stop_key_i}),
    .q_o(pin)
  );

  dam_rtc #(
    .SEC_CYC(SEC_CYC)
  ) u_rtc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .r(rtc_bus)
  );

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nv,
                                         input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = nv[8*b +: 8];
      end
    end
    return res;
  endfunction

  // writes land on the edge where the master sees ack
  assign acc = wb_cyc_i && wb_stb_i;
  assign wr = acc && wb_we_i && s.ack;
  assign rtc_bus.init = wr && wb_adr_i == dam_pkg::A_INIT && wb_sel_i[0] &&
    wb_dat_i[7:0] == dam_pkg::DATA_INIT_VAL;
  assign rtc_bus.wr_time = wr && wb_adr_i == dam_pkg::A_TIME && (&wb_sel_i[2:0]);
  assign rtc_bus.wr_date = wr && wb_adr_i == dam_pkg::A_DATE && (&wb_sel_i[2:0]);
  assign rtc_bus.wdata = wb_dat_i[23:0];

  // read mux
  always_comb begin
    rdata = '0;
    if (wb_adr_i[7:5] == dam_pkg::A_HIST_HI) begin
      rdata = {24'h0, s.hist[wb_adr_i[4:2]]};
    end else begin
      case (wb_adr_i)
        dam_pkg::A_MOCK: rdata = {24'h0, s.mock_reg};
        dam_pkg::A_INIT: rdata = {24'h0, s.init_reg};
        dam_pkg::A_TIME: rdata = {8'h0, rtc_bus.time_v};
        dam_pkg::A_DATE: rdata = {8'h0, rtc_bus.date_v};
        dam_pkg::A_SEL1: rdata = {16'h0, s.sel[15:0]};
        dam_pkg::A_SEL2: rdata = {16'h0, s.sel[31:16]};
        dam_pkg::A_ASGN: rdata = s.asgn;
        dam_pkg::A_STAT: begin
          rdata[6:0] = {rtc_bus.run, s.la, s.trip, s.dloss, s.lowb, s.mock};
          rdata[15:8] = s.code;
        end
        dam_pkg::A_ISTAT: rdata = {27'h0, s.ist};
        dam_pkg::A_IMASK: rdata = {27'h0, s.imask};
        default: rdata = '0;
      endcase
    end
  end

  always_comb begin
    next_s = s;
    ev = '0;
    new_code = '0;
    next_s.pin_q = pin;
    rkey_rise = pin[dam_pkg::PIN_RKEY] && !s.pin_q[dam_pkg::PIN_RKEY];
    term_rise = pin[dam_pkg::PIN_RST] && !s.pin_q[dam_pkg::PIN_RST];
    comm_rel = wr && wb_adr_i == dam_pkg::A_CTRL && wb_sel_i[0] &&
      wb_dat_i[dam_pkg::CTRL_REL];
    rel_req = (rkey_rise && run_mode_i) || term_rise || comm_rel;

    // bus slave: ack one cycle after the request, dropped the cycle after
    next_s.ack = acc && !s.ack;
    next_s.dat = (acc && !s.ack && !wb_we_i) ? rdata : '0;
    // unselected byte lanes keep their stored value
    if (wr) begin
      case (wb_adr_i)
        dam_pkg::A_MOCK: begin
          if (wb_sel_i[0]) begin
            next_s.mock_reg = wb_dat_i[7:0];
          end
        end
        dam_pkg::A_INIT: begin
          if (wb_sel_i[0]) begin
            next_s.init_reg = wb_dat_i[7:0];
          end
        end
        dam_pkg::A_SEL1: begin
          // causes 0 to 15
          if (wb_sel_i[0]) begin
            next_s.sel[7:0] = wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            next_s.sel[15:8] = wb_dat_i[15:8];
          end
        end
        dam_pkg::A_SEL2: begin
          // causes 16 to 31
          if (wb_sel_i[0]) begin
            next_s.sel[23:16] = wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            next_s.sel[31:24] = wb_dat_i[15:8];
          end
        end
        dam_pkg::A_ASGN: next_s.asgn = wmerge(s.asgn, wb_dat_i, wb_sel_i);
        dam_pkg::A_IMASK: begin
          if (wb_sel_i[0]) begin
            next_s.imask = wb_dat_i[dam_pkg::EV_N-1:0];
          end
        end
        default: begin
        end
      endcase
    end

    // mock alarm from key hold or setting write
    if (pin[dam_pkg::PIN_STOP] && pin[dam_pkg::PIN_SET]) begin
      if (s.hold != HOLD_CYC) begin
        next_s.hold = s.hold + 32'h1;
      end
    end else begin
      next_s.hold = '0;
    end
    if (rkey_rise) begin
      next_s.mock = 1'b0;
    end
    if (s.hold == HOLD_CYC) begin
      next_s.mock = 1'b1;
    end
    if (wr && wb_adr_i == dam_pkg::A_MOCK && wb_sel_i[0] &&
        wb_dat_i[7:0] == dam_pkg::MOCK_TRIG_VAL) begin
      next_s.mock = 1'b1;
    end

    // battery alarm clears only on reset with normal voltage
    if (pin[dam_pkg::PIN_BATT]) begin
      next_s.lowb = 1'b1;
    end else if (rkey_rise) begin
      next_s.lowb = 1'b0;
    end

    // date loss: backup lost or calendar holds an impossible date
    dloss_cond = pin[dam_pkg::PIN_LOST] || rtc_bus.bad;
    if (dloss_cond) begin
      next_s.dloss = 1'b1;
    end else if (rkey_rise) begin
      next_s.dloss = 1'b0;
    end

    // light alarm causes versus tripping causes
    la_src = cause_i & s.sel;
    rise = la_src & ~s.cause_q;
    next_s.cause_q = la_src;
    next_s.trip = |(cause_i & ~s.sel) || s.mock || s.lowb || s.dloss;
    for (int i = dam_pkg::NCAUSE - 1; i >= 0; i--) begin
      if (rise[i]) begin
        new_code = 8'(i + 1);
      end
    end

    if (|rise) begin
      next_s.la = LA_ALARM;
      next_s.code = new_code;
      next_s.hist = {s.hist[dam_pkg::HIST_D-2:0], new_code};
      ev[dam_pkg::EV_LA_ON] = s.la != LA_ALARM;
    end else begin
      unique case (s.la)
        LA_IDLE: begin
          next_s.la = LA_IDLE;
        end
        LA_ALARM: begin
          if (rel_req) begin
            if (|la_src) begin
              next_s.la = LA_RESERVED;
            end else begin
              next_s.la = LA_IDLE;
              ev[dam_pkg::EV_LA_OFF] = 1'b1;
            end
          end
        end
        LA_RESERVED: begin
          if (!(|la_src)) begin
            next_s.la = LA_IDLE;
            ev[dam_pkg::EV_LA_OFF] = 1'b1;
          end
        end
        default: begin
          // unused state code falls back to idle
          next_s.la = LA_IDLE;
        end
      endcase
    end

    // lamp flashes in alarm, steady while reserved
    if (s.la == LA_ALARM) begin
      if (s.blink_cnt == 32'(BLINK_CYC - 1)) begin
        next_s.blink_cnt = '0;
        next_s.blink = !s.blink;
      end else begin
        next_s.blink_cnt = s.blink_cnt + 32'h1;
      end
    end else begin
      next_s.blink_cnt = '0;
      next_s.blink = 1'b1;
    end
    next_s.lamp = (next_s.la == LA_ALARM) ? next_s.blink : (next_s.la == LA_RESERVED);
    next_s.code_o = (next_s.la != LA_IDLE) ? next_s.code : 8'h00;
    for (int t = 0; t < dam_pkg::NTERM; t++) begin
      next_s.lout[t] = (next_s.la != LA_IDLE) &&
        s.asgn[8*t +: 8] == dam_pkg::LALM_ASSIGN_VAL;
    end

    // sticky events, a set in the clearing cycle wins
    ev[dam_pkg::EV_MOCK] = next_s.mock && !s.mock;
    ev[dam_pkg::EV_LOWB] = next_s.lowb && !s.lowb;
    ev[dam_pkg::EV_DLOSS] = next_s.dloss && !s.dloss;
    if (wr && wb_adr_i == dam_pkg::A_ISTAT && wb_sel_i[0]) begin
      next_s.ist = s.ist & ~wb_dat_i[dam_pkg::EV_N-1:0];
    end
    next_s.ist = next_s.ist | ev;
    next_s.irq = |(next_s.ist & next_s.imask);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign wb_dat_o = s.dat;
  assign wb_ack_o = s.ack;
  assign mock_alarm_o = s.mock;
  assign low_batt_alarm_o = s.lowb;
  assign date_loss_alarm_o = s.dloss;
  assign trip_o = s.trip;
  assign caution_lamp_o = s.lamp;
  assign alarm_code_o = s.code_o;
  assign light_alarm_output_o = s.lout;
  assign irq_o = s.irq;
endmodule

// [verif/dam_checker.sv]
`timescale 1ns/1ps
module dam_checker #(
  parameter int unsigned HOLD_CYC = dam_pkg::MOCK_HOLD_CYC,
  parameter int unsigned BLINK_CYC = dam_pkg::BLINK_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus handshake
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // pins
  input wire logic stop_key_i,
  input wire logic set_key_i,
  input wire logic batt_low_i,
  input wire logic backup_lost_i,
  // alarm outputs
  input wire logic mock_alarm_o,
  input wire logic low_batt_alarm_o,
  input wire logic date_loss_alarm_o,
  input wire logic caution_lamp_o,
  input wire logic [7:0] alarm_code_o,
  input wire logic [dam_pkg::NTERM-1:0] light_alarm_output_o,
  input wire logic irq_o
);
  localparam int BW = 2 * BLINK_CYC + 1;
  int unsigned keys_cnt;
  int unsigned batt_cnt;
  int unsigned lost_cnt;
  // raw pin run lengths, ahead of the synchroniser
  always_ff @(posedge clk_i) begin
    keys_cnt <= (rst_i || !(stop_key_i && set_key_i)) ? 0 : keys_cnt + 1;
    batt_cnt <= (rst_i || !batt_low_i) ? 0 : batt_cnt + 1;
    lost_cnt <= (rst_i || !backup_lost_i) ? 0 : lost_cnt + 1;
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_bus_ack_once: assert property (
    $rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single pulse");
  a_mock_hold_fires: assert property (
    keys_cnt == HOLD_CYC + 4 |-> ##[0:6] mock_alarm_o)
    else $error("mock alarm missing after long key hold");
  a_mock_not_early: assert property (
    $rose(mock_alarm_o) && stop_key_i && set_key_i |-> keys_cnt > HOLD_CYC)
    else $error("mock alarm before hold time");
  a_battery_alarm_held: assert property (
    batt_cnt > 8 |-> low_batt_alarm_o)
    else $error("low battery alarm dropped while battery low");
  a_date_loss_held: assert property (
    lost_cnt > 8 |-> date_loss_alarm_o)
    else $error("date loss alarm missing");
  a_lamp_blinks: assert property (
    $rose(alarm_code_o != 8'h00) |-> ##[0:BW] caution_lamp_o ##[1:BW] !caution_lamp_o)
    else $error("caution lamp not flashing");
  a_idle_lamp_dark: assert property (
    alarm_code_o == 8'h00 |-> !caution_lamp_o)
    else $error("caution lamp lit without alarm");
  a_output_needs_code: assert property (
    light_alarm_output_o != '0 |-> alarm_code_o != 8'h00)
    else $error("light alarm output without alarm");
  c_mock: cover property ($rose(mock_alarm_o));
  c_reserved: cover property ((caution_lamp_o && alarm_code_o != 8'h00) [*6]);
  c_irq: cover property ($rose(irq_o));
endmodule
bind dam_top dam_checker #(.HOLD_CYC(HOLD_CYC), .BLINK_CYC(BLINK_CYC)) i_dam_checker (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .stop_key_i(stop_key_i), .set_key_i(set_key_i),
  .batt_low_i(batt_low_i), .backup_lost_i(backup_lost_i), .mock_alarm_o(mock_alarm_o),
  .low_batt_alarm_o(low_batt_alarm_o), .date_loss_alarm_o(date_loss_alarm_o),
  .caution_lamp_o(caution_lamp_o), .alarm_code_o(alarm_code_o),
  .light_alarm_output_o(light_alarm_output_o), .irq_o(irq_o)
);

// [verif/dam_panel.sv]
`timescale 1ns/1ps
module dam_panel (
  // clock
  input wire logic clk_i,
  // keys and terminal pins
  output logic stop_key_o,
  output logic set_key_o,
  output logic reset_key_o,
  output logic alarm_rst_o,
  output logic batt_low_o,
  output logic backup_lost_o
);
  initial begin
    {alarm_rst_o, reset_key_o, set_key_o, stop_key_o} = 4'h0;
    {batt_low_o, backup_lost_o} = 2'h0;
  end
  // hold a key pattern, let go, wait past the synchroniser
  task automatic press(input logic [3:0] k, input int n);
    @(posedge clk_i);
    {alarm_rst_o, reset_key_o, set_key_o, stop_key_o} <= k;
    repeat (n) @(posedge clk_i);
    {alarm_rst_o, reset_key_o, set_key_o, stop_key_o} <= 4'h0;
    repeat (8) @(posedge clk_i);
  endtask
  task automatic supply(input logic low, input logic lost);
    @(posedge clk_i);
    {batt_low_o, backup_lost_o} <= {low, lost};
    repeat (8) @(posedge clk_i);
  endtask
endmodule

// [verif/drive_alarm_manager_bench.sv]
`timescale 1ns/1ps
module drive_alarm_manager_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic run_mode_i = 1'b0;
  logic [dam_pkg::NCAUSE-1:0] cause_i = '0;
  logic stop_key_i, set_key_i, reset_key_i, alarm_rst_i, batt_low_i, backup_lost_i;
  logic mock_alarm_o, low_batt_alarm_o, date_loss_alarm_o, trip_o, caution_lamp_o, irq_o;
  logic [7:0] alarm_code_o;
  logic [dam_pkg::NTERM-1:0] light_alarm_output_o;
  logic [7:0] idle_regs [6] = '{8'h00, 8'h04, 8'h08, 8'h24, 8'h28, 8'h30};
  int num_errors = 0;
  int num_checks = 0;
  always #4 clk_i = ~clk_i;
  dam_panel i_dam_panel (.clk_i(clk_i), .stop_key_o(stop_key_i), .set_key_o(set_key_i),
    .reset_key_o(reset_key_i), .alarm_rst_o(alarm_rst_i), .batt_low_o(batt_low_i),
    .backup_lost_o(backup_lost_i));
  dam_top #(.HOLD_CYC(20), .BLINK_CYC(4), .SEC_CYC(3)) i_dam_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .stop_key_i(stop_key_i),
    .set_key_i(set_key_i), .reset_key_i(reset_key_i), .alarm_rst_i(alarm_rst_i),
    .batt_low_i(batt_low_i), .backup_lost_i(backup_lost_i), .run_mode_i(run_mode_i),
    .cause_i(cause_i), .mock_alarm_o(mock_alarm_o), .low_batt_alarm_o(low_batt_alarm_o),
    .date_loss_alarm_o(date_loss_alarm_o), .trip_o(trip_o),
    .caution_lamp_o(caution_lamp_o), .alarm_code_o(alarm_code_o),
    .light_alarm_output_o(light_alarm_output_o), .irq_o(irq_o));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    q = wb_dat_o;
    if (n == 20) chk("bus ack", 32'h0, 32'h1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, q & m, e);
  endtask
  task automatic la(input logic [7:0] code, input logic [3:0] out);
    chk("alarm code", 32'(alarm_code_o), 32'(code));
    chk("light alarm output", 32'(light_alarm_output_o), 32'(out));
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wr(8'h30, 32'hffffffff);
    foreach (idle_regs[i]) rd("idle register", idle_regs[i], 32'hffffffff, 32'h0);
    $display("test registers done");
    wr(dam_pkg::A_MOCK, 32'h1);
    repeat (3) @(posedge clk_i);
    chk("mock", 32'(mock_alarm_o), 32'h1);
    chk("trip", 32'(trip_o), 32'h1);
    chk("masked irq", 32'(irq_o), 32'h0);
    rd("mock setting", dam_pkg::A_MOCK, 32'hff, 32'h1);
    wr(dam_pkg::A_IMASK, 32'h1);
    chk("irq", 32'(irq_o), 32'h1);
    wr(dam_pkg::A_ISTAT, 32'h1);
    repeat (2) @(posedge clk_i);
    chk("irq cleared", 32'(irq_o), 32'h0);
    wr(dam_pkg::A_MOCK, 32'h0);
    i_dam_panel.press(4'h4, 6);
    chk("mock reset", 32'(mock_alarm_o), 32'h0);
    i_dam_panel.press(4'h3, 15);
    chk("mock short hold", 32'(mock_alarm_o), 32'h0);
    i_dam_panel.press(4'h3, 40);
    chk("mock long hold", 32'(mock_alarm_o), 32'h1);
    i_dam_panel.press(4'h4, 6);
    $display("test mock alarm done");
    i_dam_panel.supply(1'b1, 1'b0);
    i_dam_panel.press(4'h4, 6);
    chk("low battery held", 32'(low_batt_alarm_o), 32'h1);
    i_dam_panel.supply(1'b0, 1'b1);
    chk("date loss", 32'(date_loss_alarm_o), 32'h1);
    i_dam_panel.supply(1'b0, 1'b0);
    i_dam_panel.press(4'h4, 6);
    chk("alarms reset", {30'h0, low_batt_alarm_o, date_loss_alarm_o}, 32'h0);
    $display("test battery done");
    wr(dam_pkg::A_DATE, 32'h00630c1f);
    wr(dam_pkg::A_TIME, 32'h00173b3a);
    repeat (30) @(posedge clk_i);
    rd("time", dam_pkg::A_TIME, 32'hffffff, 32'h173b3b);
    rd("date", dam_pkg::A_DATE, 32'hffffff, 32'h630c1f);
    wr(dam_pkg::A_DATE, 32'h00630d01);
    repeat (4) @(posedge clk_i);
    chk("bad date", 32'(date_loss_alarm_o), 32'h1);
    wr(dam_pkg::A_DATE, 32'h00010101);
    rd("clock running", dam_pkg::A_STAT, 32'h40, 32'h40);
    i_dam_panel.press(4'h4, 6);
    chk("date loss reset", 32'(date_loss_alarm_o), 32'h0);
    $display("test calendar done");
    wr(dam_pkg::A_SEL1, 32'h6);
    wr(dam_pkg::A_ASGN, 32'h6200);
    rd("select", dam_pkg::A_SEL1, 32'hffff, 32'h6);
    wr(dam_pkg::A_CTRL, 32'h1);
    repeat (2) @(posedge clk_i);
    la(8'h00, 4'h0);
    cause_i <= 32'h2;
    repeat (12) @(posedge clk_i);
    la(8'h02, 4'h2);
    chk("no trip", 32'(trip_o), 32'h0);
    rd("history", 8'h40, 32'hff, 32'h2);
    cause_i <= '0;
    wr(dam_pkg::A_CTRL, 32'h1);
    repeat (2) @(posedge clk_i);
    la(8'h00, 4'h0);
    chk("lamp off", 32'(caution_lamp_o), 32'h0);
    cause_i <= 32'h4;
    repeat (12) @(posedge clk_i);
    rd("history newest", 8'h40, 32'hff, 32'h3);
    rd("history older", 8'h44, 32'hff, 32'h2);
    i_dam_panel.press(4'h8, 6);
    repeat (6) begin
      chk("steady lamp", 32'(caution_lamp_o), 32'h1);
      @(posedge clk_i);
    end
    la(8'h03, 4'h2);
    cause_i <= '0;
    repeat (3) @(posedge clk_i);
    la(8'h00, 4'h0);
    cause_i <= 32'h2;
    repeat (12) @(posedge clk_i);
    cause_i <= '0;
    i_dam_panel.press(4'h4, 6);
    la(8'h02, 4'h2);
    run_mode_i <= 1'b1;
    i_dam_panel.press(4'h4, 6);
    la(8'h00, 4'h0);
    cause_i <= 32'h8;
    repeat (4) @(posedge clk_i);
    chk("unselected trip", 32'(trip_o), 32'h1);
    la(8'h00, 4'h0);
    cause_i <= '0;
    rd("event status", dam_pkg::A_ISTAT, 32'h1e, 32'h1e);
    $display("test light alarm done");
    wr(dam_pkg::A_INIT, 32'h0a);
    rd("init setting", dam_pkg::A_INIT, 32'hff, 32'h0a);
    rd("clock stopped", dam_pkg::A_STAT, 32'h40, 32'h0);
    $display("test clock init done");
    report_and_stop();
  end
endmodule
